// *** design/tcp_pkg.sv ***
package tcp_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry and offsets
    // ------------------------------------------------------------------
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_MODE     = 8'h04;
    localparam logic [7:0]  OFF_ENABLE   = 8'h08;
    localparam logic [7:0]  OFF_STATUS   = 8'h0c;
    localparam logic [7:0]  OFF_EVGEN    = 8'h10;
    localparam logic [7:0]  OFF_COUNT    = 8'h14;
    localparam logic [7:0]  OFF_RELOAD   = 8'h18;
    localparam logic [7:0]  OFF_COMPARE  = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_DIR      = 1;
    localparam int CTRL_ALIGN_LO = 2;
    localparam int CTRL_RELOAD_PRELOAD_ENABLE     = 4;
    localparam int CTRL_DSEL     = 5;
    localparam int MODE_LO       = 0;
    localparam int MODE_PE       = 3;
    localparam int MODE_ECE      = 4;
    localparam int MODE_POL      = 5;
    localparam int MODE_OE       = 6;
    localparam int EN_IRQ        = 0;
    localparam int EN_DMA        = 1;
    localparam int ST_FLAG       = 0;
    localparam int ST_REF        = 1;
    localparam int ST_HOLD       = 2;
    localparam int EV_UG         = 0;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [31:0] RELOAD_RST   = 32'h0000_ffff;
    localparam logic [31:0] COMPARE_RST  = 32'h0000_0000;
    localparam logic [1:0]  ALIGN_EDGE   = 2'h0;
    localparam logic [1:0]  ALIGN_DOWN   = 2'h1;
    localparam logic [1:0]  ALIGN_UP     = 2'h2;
    localparam logic [1:0]  ALIGN_BOTH   = 2'h3;

    typedef enum logic [2:0] {
        MODE_FROZEN   = 3'h0,
        MODE_SET      = 3'h1,
        MODE_CLR      = 3'h2,
        MODE_TOGGLE   = 3'h3,
        MODE_FORCE_LO = 3'h4,
        MODE_FORCE_HI = 3'h5,
        MODE_PWM1     = 3'h6,
        MODE_PWM2     = 3'h7
    } tcp_mode_e;

endpackage : tcp_pkg

// *** design/tcp_channel.sv ***
// Functional notes
// - Mode 101 forces reference high.
// - Mode 100 forces reference low.
// - Forced modes still compare and flag.
// - Pin equals reference XOR polarity bit.
// - Match: keep, set, clear or toggle.
// - Match sets compare flag in status.
// - Interrupt only when interrupt enable set.
// - DMA request gated by enable, event selectable.
// - Preload off writes compare immediately; else update.
// - Update event leaves compare-mode reference alone.
// - Modes 110 and 111 select PWM.
// - Shadows load on update; software generates one.
// - Pin driven only when output enabled.
// - PWM reference moves on compare change, frozen exit or update.
// - Up PWM1: high while counter below compare.
// - Compare above reload high; zero low when counting up.
// - Down PWM1: low while counter above compare.
// - Center mode selects flag direction by alignment.
// - Center mode: hardware owns direction bit.
// - Center entry write loads direction bit from write data.
// - Center counter writes: zero/reload set direction, no update.
// - External clear holds reference low until update; forced modes ignore it.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module tcp_channel #(
    parameter int CNT_W = 16
) (
    input  wire logic                       clock,
    input  wire logic                       rstn,
    input  wire logic [tcp_pkg::ADDR_W-1:0] addr,
    input  wire logic [tcp_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr_strobe,
    input  wire logic                       rd_strobe,
    output logic      [tcp_pkg::DATA_W-1:0] rdata,
    input  wire logic                       filtered_external_trigger,
    output logic                            channel_output_pin,
    output logic                            channel_output_oe,
    output logic                            compare_irq,
    output logic                            compare_dma_req
);

    // ------------------------------------------------------------------
    // Software-visible state and shadow registers
    // ------------------------------------------------------------------
    logic                  counter_run_bit_reg;
    logic                  dir_reg;
    logic [1:0]            alignment_field_reg;
    logic                  reload_preload_enable_reg;
    logic                  dma_event_select_reg;
    tcp_pkg::tcp_mode_e    output_mode_field_reg;
    logic                  compare_preload_enable_reg;
    logic                  external_clear_enable_reg;
    logic                  output_polarity_bit_reg;
    logic                  channel_output_enable_reg;
    logic                  compare_irq_enable_reg;
    logic                  compare_dma_enable_reg;
    logic                  compare_match_flag_reg;
    logic [CNT_W-1:0]      counter_value_reg;
    logic [CNT_W-1:0]      reload_pre_reg;
    logic [CNT_W-1:0]      reload_shadow_reg;
    logic [CNT_W-1:0]      compare_pre_reg;
    logic [CNT_W-1:0]      compare_shadow_reg;

    // ------------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------------
    logic                  ref_reg;
    logic                  clear_hold_reg;
    logic                  step_d_reg;
    logic                  level_d_reg;
    tcp_pkg::tcp_mode_e    mode_d_reg;
    logic [tcp_pkg::DATA_W-1:0] rdata_reg;
    logic                  pin_reg;
    logic                  oe_reg;
    logic                  irq_reg;
    logic                  dma_reg;

    logic                  wr_ctrl;
    logic                  wr_mode;
    logic                  wr_enable;
    logic                  wr_status;
    logic                  wr_count;
    logic                  wr_reload;
    logic                  wr_compare;
    logic                  update_generate_bit;
    logic                  center;

    logic [CNT_W-1:0]      counter_next;
    logic                  dir_next;
    logic                  update_event;
    logic                  stepped;
    logic                  match;
    logic                  flag_set;
    logic                  pwm1_level;
    logic                  pwm_level;
    logic                  is_pwm;
    logic                  is_forced;

    assign wr_ctrl    = wr_strobe && (addr == tcp_pkg::OFF_CTRL);
    assign wr_mode    = wr_strobe && (addr == tcp_pkg::OFF_MODE);
    assign wr_enable  = wr_strobe && (addr == tcp_pkg::OFF_ENABLE);
    assign wr_status  = wr_strobe && (addr == tcp_pkg::OFF_STATUS);
    assign wr_count   = wr_strobe && (addr == tcp_pkg::OFF_COUNT);
    assign wr_reload  = wr_strobe && (addr == tcp_pkg::OFF_RELOAD);
    assign wr_compare = wr_strobe && (addr == tcp_pkg::OFF_COMPARE);
    assign update_generate_bit = wr_strobe && (addr == tcp_pkg::OFF_EVGEN) && wdata[tcp_pkg::EV_UG];
    assign center     = (alignment_field_reg != tcp_pkg::ALIGN_EDGE);
    assign is_pwm     = (output_mode_field_reg == tcp_pkg::MODE_PWM1) ||
                        (output_mode_field_reg == tcp_pkg::MODE_PWM2);
    assign is_forced  = (output_mode_field_reg == tcp_pkg::MODE_FORCE_LO) ||
                        (output_mode_field_reg == tcp_pkg::MODE_FORCE_HI);

    // ------------------------------------------------------------------
    // Time base: counter, direction and update event
    // ------------------------------------------------------------------
    always_comb begin
        counter_next = counter_value_reg;
        dir_next     = dir_reg;
        update_event = 1'b0;
        stepped      = 1'b0;
        if (update_generate_bit) begin
            update_event = 1'b1;
            stepped      = 1'b1;
            if (!center && dir_reg) begin
                counter_next = reload_pre_reg;
            end else begin
                counter_next = '0;
            end
        end else if (wr_count) begin
            counter_next = wdata[CNT_W-1:0];
            stepped      = 1'b1;
            if (center) begin
                if (wdata[CNT_W-1:0] == '0) begin
                    dir_next = 1'b0;
                end else if (wdata[CNT_W-1:0] == reload_shadow_reg) begin
                    dir_next = 1'b1;
                end
            end
        end else if (counter_run_bit_reg) begin
            stepped = 1'b1;
            if (!dir_reg) begin
                if (counter_value_reg >= reload_shadow_reg) begin
                    update_event = 1'b1;
                    if (center) begin
                        counter_next = reload_shadow_reg - CNT_W'(1);
                        dir_next     = 1'b1;
                    end else begin
                        counter_next = '0;
                    end
                end else begin
                    counter_next = counter_value_reg + CNT_W'(1);
                end
            end else begin
                if (counter_value_reg == '0) begin
                    update_event = 1'b1;
                    if (center) begin
                        counter_next = CNT_W'(1);
                        dir_next     = 1'b0;
                    end else begin
                        counter_next = reload_shadow_reg;
                    end
                end else begin
                    counter_next = counter_value_reg - CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            counter_value_reg <= '0;
            dir_reg           <= 1'b0;
            step_d_reg        <= 1'b0;
        end else begin
            counter_value_reg <= counter_next;
            step_d_reg        <= stepped;
            if (wr_ctrl && !center) begin
                dir_reg <= wdata[tcp_pkg::CTRL_DIR];
            end else begin
                dir_reg <= dir_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            counter_run_bit_reg        <= 1'b0;
            alignment_field_reg        <= tcp_pkg::ALIGN_EDGE;
            reload_preload_enable_reg  <= 1'b0;
            dma_event_select_reg       <= 1'b0;
            output_mode_field_reg      <= tcp_pkg::MODE_FROZEN;
            compare_preload_enable_reg <= 1'b0;
            external_clear_enable_reg  <= 1'b0;
            output_polarity_bit_reg    <= 1'b0;
            channel_output_enable_reg  <= 1'b0;
            compare_irq_enable_reg     <= 1'b0;
            compare_dma_enable_reg     <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                counter_run_bit_reg       <= wdata[tcp_pkg::CTRL_RUN];
                alignment_field_reg       <= wdata[tcp_pkg::CTRL_ALIGN_LO +: 2];
                reload_preload_enable_reg <= wdata[tcp_pkg::CTRL_RELOAD_PRELOAD_ENABLE];
                dma_event_select_reg      <= wdata[tcp_pkg::CTRL_DSEL];
            end
            if (wr_mode) begin
                output_mode_field_reg      <= tcp_pkg::tcp_mode_e'(wdata[tcp_pkg::MODE_LO +: 3]);
                compare_preload_enable_reg <= wdata[tcp_pkg::MODE_PE];
                external_clear_enable_reg  <= wdata[tcp_pkg::MODE_ECE];
                output_polarity_bit_reg    <= wdata[tcp_pkg::MODE_POL];
                channel_output_enable_reg  <= wdata[tcp_pkg::MODE_OE];
            end
            if (wr_enable) begin
                compare_irq_enable_reg <= wdata[tcp_pkg::EN_IRQ];
                compare_dma_enable_reg <= wdata[tcp_pkg::EN_DMA];
            end
        end
    end

    // ------------------------------------------------------------------
    // Preload and shadow registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            reload_pre_reg     <= tcp_pkg::RELOAD_RST[CNT_W-1:0];
            reload_shadow_reg  <= tcp_pkg::RELOAD_RST[CNT_W-1:0];
            compare_pre_reg    <= tcp_pkg::COMPARE_RST[CNT_W-1:0];
            compare_shadow_reg <= tcp_pkg::COMPARE_RST[CNT_W-1:0];
        end else begin
            if (wr_reload) begin
                reload_pre_reg <= wdata[CNT_W-1:0];
            end
            if (wr_compare) begin
                compare_pre_reg <= wdata[CNT_W-1:0];
            end
            if (update_event) begin
                reload_shadow_reg  <= reload_pre_reg;
                compare_shadow_reg <= compare_pre_reg;
            end
            if (wr_reload && !reload_preload_enable_reg) begin
                reload_shadow_reg <= wdata[CNT_W-1:0];
            end
            if (wr_compare && !compare_preload_enable_reg) begin
                compare_shadow_reg <= wdata[CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Comparator and compare flag
    // ------------------------------------------------------------------
    // A match is taken once per counter step, so a stopped counter does not keep matching.
    assign match = step_d_reg && (counter_value_reg == compare_shadow_reg);

    always_comb begin
        case (alignment_field_reg)
            tcp_pkg::ALIGN_EDGE: flag_set = match;
            tcp_pkg::ALIGN_DOWN: flag_set = match && dir_reg;
            tcp_pkg::ALIGN_UP:   flag_set = match && !dir_reg;
            tcp_pkg::ALIGN_BOTH: flag_set = match;
            default:             flag_set = match;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            compare_match_flag_reg <= 1'b0;
        end else if (flag_set) begin
            compare_match_flag_reg <= 1'b1;
        end else if (wr_status && !wdata[tcp_pkg::ST_FLAG]) begin
            compare_match_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Reference waveform
    // ------------------------------------------------------------------
    assign pwm1_level = dir_reg ? (counter_value_reg <= compare_shadow_reg)
                                : (counter_value_reg < compare_shadow_reg);
    assign pwm_level  = (output_mode_field_reg == tcp_pkg::MODE_PWM2) ? !pwm1_level : pwm1_level;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            clear_hold_reg <= 1'b0;
        end else if (external_clear_enable_reg && filtered_external_trigger && !is_forced) begin
            clear_hold_reg <= 1'b1;
        end else if (update_event) begin
            clear_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ref_reg     <= 1'b0;
            level_d_reg <= 1'b0;
            mode_d_reg  <= tcp_pkg::MODE_FROZEN;
        end else begin
            level_d_reg <= pwm_level;
            mode_d_reg  <= output_mode_field_reg;
            if (!is_forced && ((clear_hold_reg && !update_event) ||
                               (external_clear_enable_reg && filtered_external_trigger))) begin
                ref_reg <= 1'b0;
            end else begin
                case (output_mode_field_reg)
                    tcp_pkg::MODE_FROZEN:   ref_reg <= ref_reg;
                    tcp_pkg::MODE_SET:      ref_reg <= match ? 1'b1 : ref_reg;
                    tcp_pkg::MODE_CLR:      ref_reg <= match ? 1'b0 : ref_reg;
                    tcp_pkg::MODE_TOGGLE:   ref_reg <= match ? !ref_reg : ref_reg;
                    tcp_pkg::MODE_FORCE_LO: ref_reg <= 1'b0;
                    tcp_pkg::MODE_FORCE_HI: ref_reg <= 1'b1;
                    tcp_pkg::MODE_PWM1,
                    tcp_pkg::MODE_PWM2: begin
                        if ((pwm_level != level_d_reg) || (mode_d_reg == tcp_pkg::MODE_FROZEN) ||
                            update_event) begin
                            ref_reg <= pwm_level;
                        end
                    end
                    default:                ref_reg <= ref_reg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Output pin, interrupt and DMA request
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pin_reg <= 1'b0;
            oe_reg  <= 1'b0;
            irq_reg <= 1'b0;
            dma_reg <= 1'b0;
        end else begin
            pin_reg <= channel_output_enable_reg && (ref_reg ^ output_polarity_bit_reg);
            oe_reg  <= channel_output_enable_reg;
            irq_reg <= compare_irq_enable_reg && compare_match_flag_reg;
            dma_reg <= compare_dma_enable_reg &&
                       (dma_event_select_reg ? update_event : flag_set);
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else if (rd_strobe) begin
            rdata_reg <= '0;
            case (addr)
                tcp_pkg::OFF_CTRL: begin
                    rdata_reg[tcp_pkg::CTRL_RUN]          <= counter_run_bit_reg;
                    rdata_reg[tcp_pkg::CTRL_DIR]          <= dir_reg;
                    rdata_reg[tcp_pkg::CTRL_ALIGN_LO +: 2] <= alignment_field_reg;
                    rdata_reg[tcp_pkg::CTRL_RELOAD_PRELOAD_ENABLE]         <= reload_preload_enable_reg;
                    rdata_reg[tcp_pkg::CTRL_DSEL]         <= dma_event_select_reg;
                end
                tcp_pkg::OFF_MODE: begin
                    rdata_reg[tcp_pkg::MODE_LO +: 3] <= output_mode_field_reg;
                    rdata_reg[tcp_pkg::MODE_PE]      <= compare_preload_enable_reg;
                    rdata_reg[tcp_pkg::MODE_ECE]     <= external_clear_enable_reg;
                    rdata_reg[tcp_pkg::MODE_POL]     <= output_polarity_bit_reg;
                    rdata_reg[tcp_pkg::MODE_OE]      <= channel_output_enable_reg;
                end
                tcp_pkg::OFF_ENABLE: begin
                    rdata_reg[tcp_pkg::EN_IRQ] <= compare_irq_enable_reg;
                    rdata_reg[tcp_pkg::EN_DMA] <= compare_dma_enable_reg;
                end
                tcp_pkg::OFF_STATUS: begin
                    rdata_reg[tcp_pkg::ST_FLAG] <= compare_match_flag_reg;
                    rdata_reg[tcp_pkg::ST_REF]  <= ref_reg;
                    rdata_reg[tcp_pkg::ST_HOLD] <= clear_hold_reg;
                end
                tcp_pkg::OFF_COUNT:   rdata_reg[CNT_W-1:0] <= counter_value_reg;
                tcp_pkg::OFF_RELOAD:  rdata_reg[CNT_W-1:0] <= reload_pre_reg;
                tcp_pkg::OFF_COMPARE: rdata_reg[CNT_W-1:0] <= compare_pre_reg;
                default:              rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata              = rdata_reg;
    assign channel_output_pin = pin_reg;
    assign channel_output_oe  = oe_reg;
    assign compare_irq        = irq_reg;
    assign compare_dma_req    = dma_reg;

endmodule : tcp_channel

`default_nettype wire

// *** tb/tcp_channel_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_channel_sva #(
    parameter int CNT_W = 16
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_strobe,
    input wire logic        channel_output_pin,
    input wire logic        channel_output_oe,
    input wire logic        compare_irq,
    input wire logic        compare_dma_req
);
    // ------------------------------------------------------------------
    // Output stage properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic mw;
    logic ew;
    assign mw = wr_strobe && addr == tcp_pkg::OFF_MODE && wdata[6];
    assign ew = wr_strobe && addr == tcp_pkg::OFF_ENABLE;
    a_pin_gated: assert property (!channel_output_oe |-> !channel_output_pin)
        else $error("pin high while output disabled");
    a_oe_follows: assert property (wr_strobe && addr == tcp_pkg::OFF_MODE |->
        ##2 channel_output_oe == $past(wdata[6], 2))
        else $error("output enable does not follow mode write");
    a_force_high: assert property (mw && wdata[5:0] == 6'h05 |-> ##[2:4] channel_output_pin)
        else $error("forced high not seen");
    a_force_low: assert property (mw && wdata[5:0] == 6'h04 |->
        ##[2:4] channel_output_oe && !channel_output_pin)
        else $error("forced low not seen");
    a_polarity_inverts: assert property (mw && wdata[5:0] == 6'h25 |->
        ##[2:4] channel_output_oe && !channel_output_pin)
        else $error("inverted forced high not seen");
    a_irq_masked: assert property (ew && !wdata[0] |-> ##2 !compare_irq [*3])
        else $error("interrupt while masked");
    a_dma_masked: assert property (ew && !wdata[1] |-> ##2 !compare_dma_req [*3])
        else $error("dma request while disabled");
    a_dma_single: assert property ($rose(compare_dma_req) |=> !compare_dma_req)
        else $error("dma request longer than one cycle");
    cover property ($rose(compare_irq));
    cover property ($rose(compare_dma_req));
    cover property ($fell(channel_output_pin) && channel_output_oe);
endmodule : tcp_channel_sva
`default_nettype wire

// *** tb/tcp_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_load_model (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        drive,
    input  wire logic        oe,
    output logic             level,
    output logic [31:0]      rises
);
    // ------------------------------------------------------------------
    // Load with a pull-down, so a released pin reads low
    // ------------------------------------------------------------------
    logic prev;
    assign level = oe ? drive : 1'b0;
    always_ff @(posedge clock) begin
        prev <= level;
        if (!rstn) rises <= 32'h0;
        else if (level && !prev) rises <= rises + 32'h1;
    end
endmodule : tcp_load_model
`default_nettype wire

// *** tb/test_tcp_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
module test_tcp_channel;
    // ------------------------------------------------------------------
    // Stimulus, partner and checks
    // ------------------------------------------------------------------
    localparam int R = 9;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_strobe = 1'b0;
    logic        rd_strobe = 1'b0;
    logic        trig = 1'b0;
    logic [31:0] rdata, d, rises, r0;
    logic        pin, oe, irq, dma, level;
    int          n_fail = 0, checks = 0, n_dma = 0, hi, c, md, dr;
    integer      seed = 32'h26e19eb0;
    always #10 clock = ~clock;
    always @(posedge clock) if (dma === 1'b1) n_dma <= n_dma + 1;
    tcp_channel #(.CNT_W(16)) DUT (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata), .filtered_external_trigger(trig), .channel_output_pin(pin),
        .channel_output_oe(oe), .compare_irq(irq), .compare_dma_req(dma));
    tcp_load_model u_load (.clock(clock), .rstn(rstn), .drive(pin), .oe(oe), .level(level), .rises(rises));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1 d = rdata;
    endtask : rd
    function automatic int duty(int m, int dn, int cv);
        int h;
        h = dn ? cv + 1 : cv;
        if (h > R + 1) h = R + 1;
        return (m == 7) ? R + 1 - h : h;
    endfunction : duty
    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rd(8'hfc);
        `CHK("unmapped", 32'h0, d)
        rd(tcp_pkg::OFF_RELOAD);
        `CHK("reload", tcp_pkg::RELOAD_RST, d)
        for (int i = 0; i < 4; i++) begin
            wr(tcp_pkg::OFF_MODE, {25'h0, 1'b1, i[1], 2'h0, 1'b1, 1'b0, i[0]});
            repeat (4) @(posedge clock);
            #1 `CHK("forced", i[0] ^ i[1], pin)
        end
        wr(tcp_pkg::OFF_MODE, 32'h05);
        repeat (4) @(posedge clock);
        #1 `CHK("disabled", 1'b0, level)
        wr(tcp_pkg::OFF_RELOAD, R);
        wr(tcp_pkg::OFF_COMPARE, 32'h3);
        wr(tcp_pkg::OFF_MODE, 32'h43);
        wr(tcp_pkg::OFF_ENABLE, 32'h3);
        wr(tcp_pkg::OFF_EVGEN, 32'h1);
        wr(tcp_pkg::OFF_CTRL, 32'h1);
        r0 = rises;
        hi = n_dma;
        repeat (4 * (R + 1)) @(posedge clock);
        `CHK("toggles", 32'h2, rises - r0)
        `CHK("dma", hi + 4, n_dma)
        rd(tcp_pkg::OFF_STATUS);
        `CHK("flag", 1'b1, d[0])
        `CHK("irq", 1'b1, irq)
        wr(tcp_pkg::OFF_STATUS, 32'h0);
        wr(tcp_pkg::OFF_MODE, 32'h45);
        repeat (R + 4) @(posedge clock);
        rd(tcp_pkg::OFF_STATUS);
        `CHK("forced flag", 1'b1, d[0])
        wr(tcp_pkg::OFF_ENABLE, 32'h0);
        for (int k = 0; k < 10; k++) begin
            c = (k == 0) ? 0 : (k == 1) ? R + 1 : $unsigned($random(seed)) % (R + 3);
            md = (k < 2) ? 6 : 6 + $unsigned($random(seed)) % 2;
            dr = (k < 2) ? 0 : $unsigned($random(seed)) % 2;
            wr(tcp_pkg::OFF_CTRL, 32'h0);
            wr(tcp_pkg::OFF_COMPARE, c);
            wr(tcp_pkg::OFF_MODE, 32'h40 | md);
            wr(tcp_pkg::OFF_CTRL, dr << 1);
            wr(tcp_pkg::OFF_EVGEN, 32'h1);
            wr(tcp_pkg::OFF_CTRL, 1 | (dr << 1));
            repeat (2 * (R + 1)) @(posedge clock);
            hi = 0;
            repeat (R + 1) begin
                @(posedge clock);
                #1 hi += pin;
            end
            `CHK("duty", duty(md, dr, c), hi)
        end
        wr(tcp_pkg::OFF_MODE, 32'h56);
        wr(tcp_pkg::OFF_COMPARE, R + 1);
        wr(tcp_pkg::OFF_EVGEN, 32'h1);
        trig <= 1'b1;
        @(posedge clock);
        trig <= 1'b0;
        repeat (3) @(posedge clock);
        #1 `CHK("cleared", 1'b0, pin)
        repeat (R + 4) @(posedge clock);
        #1 `CHK("restored", 1'b1, pin)
        wr(tcp_pkg::OFF_CTRL, 32'h0);
        wr(tcp_pkg::OFF_COMPARE, 32'h2);
        wr(tcp_pkg::OFF_STATUS, 32'h0);
        wr(tcp_pkg::OFF_EVGEN, 32'h1);
        wr(tcp_pkg::OFF_CTRL, 32'h5);
        repeat (2) @(posedge clock);
        rd(tcp_pkg::OFF_STATUS);
        `CHK("up flag", 1'b0, d[0])
        repeat (13) @(posedge clock);
        rd(tcp_pkg::OFF_STATUS);
        `CHK("down flag", 1'b1, d[0])
        wr(tcp_pkg::OFF_COUNT, R);
        rd(tcp_pkg::OFF_CTRL);
        `CHK("dir top", 4'h7, d[3:0])
        wr(tcp_pkg::OFF_COUNT, 32'h0);
        wr(tcp_pkg::OFF_CTRL, 32'h7);
        rd(tcp_pkg::OFF_CTRL);
        `CHK("dir kept", 4'h5, d[3:0])
        report_and_stop;
    end
endmodule : test_tcp_channel
bind tcp_channel tcp_channel_sva #(.CNT_W(CNT_W)) u_sva (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .channel_output_pin(channel_output_pin), .channel_output_oe(channel_output_oe),
    .compare_irq(compare_irq), .compare_dma_req(compare_dma_req));
`default_nettype wire
